// *** src/adc_seq_consts.svh ***
// Overview of operation
// - Software may read and write the sequence control register at any time.
// - Every sequence control write starts a new sequence with new settings.
// - A control write during a sequence aborts it and clears all done flags.
// - The eight-conversion bit picks four (clear) or eight (set) conversions.
// - Scan clear runs one sequence; scan set repeats until the next write.
// - Group enable clear converts the one selected input every conversion.
// - Group enable set converts the group's inputs one each, ascending.
// - Four-conversion groups are inputs 0-3, 4-7, 8-11 or 12-15, results in slots 0-3.
// - Further codes pick high ref, low ref, midpoint, test, or reserved.
// - Sequence end sets the complete flag and interrupts when enabled.
// - A clock control write aborts and halts until the next sequence write.
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define ADC_IDX_CLK      8'h64
`define ADC_IDX_SEQ      8'h65
`define ADC_IDX_STAT     8'h66
`define ADC_IDX_FLAGS    8'h67
`define ADC_IDX_IRQ_STAT 8'h68
`define ADC_IDX_IRQ_EN   8'h69
`define ADC_IDX_IRQ_CLR  8'h6a
`define ADC_IDX_RES0     8'h70

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define ADC_SEQ_RST      8'h00
`define ADC_SEQ_WMASK    8'h7f
`define ADC_SEQ_EIGHT    6
`define ADC_SEQ_SCAN     5
`define ADC_SEQ_CHANNEL_GROUP_ENABLE     4
`define ADC_CLK_RST      8'h01
`define ADC_CLK_WMASK    8'h1f
`define ADC_LAST_OF_4    3'h3
`define ADC_LAST_OF_8    3'h7
`define ADC_GRP4_MASK    4'hc
`define ADC_GRP8_MASK    4'h8
`define ADC_IRQ_SEQ      0
`define ADC_IRQ_ABORT    1
`define ADC_IRQ_W        2

`endif

// *** src/adc_seq_pkg.sv ***
package adc_seq_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_WAIT
  } adc_state_t;

endpackage : adc_seq_pkg

// *** src/adc_seq_clkdiv.sv ***
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

// Conversion clock enable: one pulse every 2*(p+1) cycles, p=0 acts as 1
module adc_seq_clkdiv (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       restart,
  input  wire logic [4:0] prescale,
  output logic            tick
);

  logic [5:0] cnt_reg;
  logic [5:0] term;

  // Zero prescale behaves as one, giving divide by four
  always_comb begin
    term = (prescale == 5'h00) ? 6'h03 : {prescale, 1'b1};
  end

  // Restarted on any prescaler write so the new rate applies at once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 6'h00;
      tick    <= 1'b0;
    end else if (restart || cnt_reg >= term) begin
      cnt_reg <= 6'h00;
      tick    <= !restart;
    end else begin
      cnt_reg <= cnt_reg + 6'h01;
      tick    <= 1'b0;
    end
  end

endmodule : adc_seq_clkdiv

// *** src/adc_seq_irq.sv ***
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

// Sticky event bits, enable mask, write-one clear, one level interrupt
module adc_seq_irq (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic [`ADC_IRQ_W-1:0]   event_in,
  input  wire logic                    clr_wr,
  input  wire logic                    en_wr,
  input  wire logic [`ADC_IRQ_W-1:0]   wdata,
  output logic      [`ADC_IRQ_W-1:0]   status,
  output logic      [`ADC_IRQ_W-1:0]   enable,
  output logic                         irq
);

  // Enable register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= '0;
    end else if (en_wr) begin
      enable <= wdata;
    end
  end

  // Per bit sticky flag; a new event wins over a clear in the same cycle
  genvar i;
  generate
    for (i = 0; i < `ADC_IRQ_W; i = i + 1) begin : g_flag
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          status[i] <= 1'b0;
        end else if (event_in[i]) begin
          status[i] <= 1'b1;
        end else if (clr_wr && wdata[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Level output while any enabled flag stands
  assign irq = |(status & enable);

endmodule : adc_seq_irq

// *** src/adc_seq_ctrl.sv ***
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module adc_seq_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             adc_irq,
  output logic             adc_clk_en,
  output logic             conv_start,
  output logic             conv_abort,
  output logic      [3:0]  conv_chan,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_result
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]              clk_ctl_reg;
  logic [7:0]              seq_ctl_reg;
  adc_seq_pkg::adc_state_t state_reg;
  logic [2:0]              conv_idx_reg;
  logic                    halted_reg;
  logic                    seq_done_reg;
  logic [7:0]              conv_flags_reg;
  logic [9:0]              result_reg [0:7];
  logic                    ack_reg;
  logic                    err_reg;
  logic [31:0]             rd_next;
  logic [11:0]             res_base;
  logic                    hit_next;
  logic                    xfer;
  logic                    wr_xfer;
  logic                    rd_xfer;
  logic                    sel_clk;
  logic                    sel_seq;
  logic                    sel_irq_en;
  logic                    sel_irq_clr;
  logic                    sel_res;
  logic                    seq_wr;
  logic                    clk_wr;
  logic                    any_ctl_wr;
  logic                    running;
  logic                    eight_conv_select;
  logic                    scan_enable;
  logic                    channel_group_enable;
  logic [3:0]              chan_code;
  logic [2:0]              last_idx;
  logic [3:0]              chan_next;
  logic                    store;
  logic                    seq_end;
  logic                    tick;
  logic [`ADC_IRQ_W-1:0]   irq_event;
  logic [`ADC_IRQ_W-1:0]   irq_status;
  logic [`ADC_IRQ_W-1:0]   irq_enable;

  // Byte address of a register index
  function automatic logic [11:0] addr_of(input logic [7:0] idx);
    addr_of = {2'b00, idx, 2'b00};
  endfunction : addr_of

  // ****************************************************************
  // APB slave
  // ****************************************************************

  // One wait state: data and error are registered on the edge that raises pready
  assign xfer    = psel & penable & ack_reg;
  assign wr_xfer = xfer & pwrite;
  assign rd_xfer = xfer & !pwrite;
  assign pready  = ack_reg;
  assign pslverr = ack_reg & err_reg;
  // Result window base, named so its upper bits can be sliced
  assign res_base = addr_of(`ADC_IDX_RES0);

  // Address decode and read mux
  always_comb begin
    rd_next     = 32'h0000_0000;
    hit_next    = 1'b1;
    sel_clk     = 1'b0;
    sel_seq     = 1'b0;
    sel_irq_en  = 1'b0;
    sel_irq_clr = 1'b0;
    sel_res     = 1'b0;
    if (paddr == addr_of(`ADC_IDX_CLK)) begin
      sel_clk = 1'b1;
      rd_next = {24'h00_0000, clk_ctl_reg};
    end else if (paddr == addr_of(`ADC_IDX_SEQ)) begin
      sel_seq = 1'b1;
      rd_next = {24'h00_0000, seq_ctl_reg};
    end else if (paddr == addr_of(`ADC_IDX_STAT)) begin
      rd_next = {25'h000_0000, conv_idx_reg, 1'b0, halted_reg,
                 running, seq_done_reg};
    end else if (paddr == addr_of(`ADC_IDX_FLAGS)) begin
      rd_next = {24'h00_0000, conv_flags_reg};
    end else if (paddr == addr_of(`ADC_IDX_IRQ_STAT)) begin
      rd_next = {{(32-`ADC_IRQ_W){1'b0}}, irq_status};
    end else if (paddr == addr_of(`ADC_IDX_IRQ_EN)) begin
      sel_irq_en = 1'b1;
      rd_next    = {{(32-`ADC_IRQ_W){1'b0}}, irq_enable};
    end else if (paddr == addr_of(`ADC_IDX_IRQ_CLR)) begin
      sel_irq_clr = 1'b1;
    end else if (paddr[11:5] == res_base[11:5] &&
                 paddr[1:0] == 2'b00) begin
      sel_res = 1'b1;
      rd_next = {22'h00_0000, result_reg[paddr[4:2]]};
    end else begin
      hit_next = 1'b0;
    end
  end

  // Handshake: pready high for one cycle per access
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !ack_reg) begin
      ack_reg <= 1'b1;
      err_reg <= !hit_next;
      prdata  <= pwrite ? 32'h0000_0000 : rd_next;
    end else begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  assign seq_wr     = wr_xfer & sel_seq;
  assign clk_wr     = wr_xfer & sel_clk;
  assign any_ctl_wr = seq_wr | clk_wr;

  // Sequence control, writable at any time; top bit reads zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_ctl_reg <= `ADC_SEQ_RST;
    end else if (seq_wr) begin
      seq_ctl_reg <= pwdata[7:0] & `ADC_SEQ_WMASK;
    end
  end

  // Clock and prescaler control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_ctl_reg <= `ADC_CLK_RST;
    end else if (clk_wr) begin
      clk_ctl_reg <= pwdata[7:0] & `ADC_CLK_WMASK;
    end
  end

  assign eight_conv_select    = seq_ctl_reg[`ADC_SEQ_EIGHT];
  assign scan_enable          = seq_ctl_reg[`ADC_SEQ_SCAN];
  assign channel_group_enable = seq_ctl_reg[`ADC_SEQ_CHANNEL_GROUP_ENABLE];
  assign chan_code            = seq_ctl_reg[3:0];

  // Four or eight conversions per sequence
  assign last_idx = eight_conv_select ? `ADC_LAST_OF_8
                                      : `ADC_LAST_OF_4;

  // ****************************************************************
  // Channel selection
  // ****************************************************************

  // Codes pass straight to the mux when group enable is clear; 12..14 are the internal references
  always_comb begin
    if (!channel_group_enable) begin
      chan_next = chan_code;
    end else if (eight_conv_select) begin
      chan_next = (chan_code & `ADC_GRP8_MASK) | {1'b0, conv_idx_reg};
    end else begin
      chan_next = (chan_code & `ADC_GRP4_MASK)
                | {2'b00, conv_idx_reg[1:0]};
    end
  end

  // ****************************************************************
  // Conversion clock
  // ****************************************************************
  adc_seq_clkdiv u_clkdiv (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .restart  (clk_wr),
    .prescale (clk_ctl_reg[4:0]),
    .tick     (tick)
  );

  assign adc_clk_en = tick;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign running = (state_reg != adc_seq_pkg::ST_IDLE);
  // A result arriving with a control write is dropped: the write aborts
  assign store   = (state_reg == adc_seq_pkg::ST_WAIT) & conv_done
                 & !any_ctl_wr;
  assign seq_end = store & (conv_idx_reg == last_idx);

  // Sequence state; a new sequence write always restarts from conversion zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= adc_seq_pkg::ST_IDLE;
      conv_idx_reg <= 3'h0;
      halted_reg   <= 1'b0;
    end else if (seq_wr) begin
      state_reg    <= adc_seq_pkg::ST_START;
      conv_idx_reg <= 3'h0;
      halted_reg   <= 1'b0;
    end else if (clk_wr) begin
      state_reg    <= adc_seq_pkg::ST_IDLE;
      conv_idx_reg <= 3'h0;
      halted_reg   <= 1'b1;
    end else begin
      case (state_reg)
        adc_seq_pkg::ST_START: begin
          if (tick) begin
            state_reg <= adc_seq_pkg::ST_WAIT;
          end
        end
        adc_seq_pkg::ST_WAIT: begin
          if (seq_end) begin
            conv_idx_reg <= 3'h0;
            state_reg    <= scan_enable ? adc_seq_pkg::ST_START
                                        : adc_seq_pkg::ST_IDLE;
          end else if (store) begin
            conv_idx_reg <= conv_idx_reg + 3'h1;
            state_reg    <= adc_seq_pkg::ST_START;
          end
        end
        default: begin
          state_reg <= adc_seq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Start pulse and channel toward the core, aligned to the conversion clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_start <= 1'b0;
      conv_chan  <= 4'h0;
    end else if (!any_ctl_wr && tick &&
                 state_reg == adc_seq_pkg::ST_START) begin
      conv_start <= 1'b1;
      conv_chan  <= chan_next;
    end else begin
      conv_start <= 1'b0;
    end
  end

  // Abort pulse when a write cuts off a running sequence
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_abort <= 1'b0;
    end else begin
      conv_abort <= any_ctl_wr & running;
    end
  end

  // ****************************************************************
  // Results and done flags
  // ****************************************************************

  // Sequence done: set at each sequence end, cleared by any control write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_done_reg <= 1'b0;
    end else if (any_ctl_wr) begin
      seq_done_reg <= 1'b0;
    end else if (seq_end) begin
      seq_done_reg <= 1'b1;
    end
  end

  // Slot k holds conversion k; reading a slot clears its flag
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_slot
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          result_reg[k] <= 10'h000;
        end else if (store && conv_idx_reg == 3'(k)) begin
          result_reg[k] <= conv_result;
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          conv_flags_reg[k] <= 1'b0;
        end else if (any_ctl_wr) begin
          conv_flags_reg[k] <= 1'b0;
        end else if (store && conv_idx_reg == 3'(k)) begin
          conv_flags_reg[k] <= 1'b1;
        end else if (rd_xfer && sel_res && paddr[4:2] == 3'(k)) begin
          conv_flags_reg[k] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_event[`ADC_IRQ_SEQ]   = seq_end;
  assign irq_event[`ADC_IRQ_ABORT] = any_ctl_wr & running;

  adc_seq_irq u_irq (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .event_in (irq_event),
    .clr_wr   (wr_xfer & sel_irq_clr),
    .en_wr    (wr_xfer & sel_irq_en),
    .wdata    (pwdata[`ADC_IRQ_W-1:0]),
    .status   (irq_status),
    .enable   (irq_enable),
    .irq      (adc_irq)
  );

endmodule : adc_seq_ctrl

// *** dv/adc_seq_core_model.sv ***
`timescale 1ns/1ps

// ****************
// Converter core
// ****************
module adc_seq_core_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       slow,
  input  wire logic       conv_start,
  input  wire logic       conv_abort,
  input  wire logic [3:0] conv_chan,
  output logic            conv_done,
  output logic      [9:0] conv_result
);
  logic [3:0] cnt_reg;

  // Countdown per conversion; bus toggles while no result is valid
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg     <= 4'h0;
      conv_done   <= 1'b0;
      conv_result <= 10'h000;
    end else begin
      conv_done   <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_abort) begin
        cnt_reg <= 4'h0;
      end else if (conv_start) begin
        cnt_reg <= slow ? 4'h7 : 4'h2;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          conv_done   <= 1'b1;
          conv_result <= {conv_chan, 2'b01, conv_chan};
        end
      end
    end
  end
endmodule : adc_seq_core_model

// *** dv/adc_seq_ctrl_monitor.sv ***
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

// ****************
// Port checker
// ****************
module adc_seq_ctrl_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        adc_irq,
  input wire logic        adc_clk_en,
  input wire logic        conv_start,
  input wire logic        conv_abort,
  input wire logic [3:0]  conv_chan,
  input wire logic        conv_done,
  input wire logic [9:0]  conv_result
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  localparam logic [11:0] A_CLK = {2'b00, `ADC_IDX_CLK, 2'b00};
  localparam logic [11:0] A_SEQ = {2'b00, `ADC_IDX_SEQ, 2'b00};

  // Access phase still waiting, and a one-cycle start
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_start_pulse;
    conv_start ##1 !conv_start;
  endsequence

  a_ready_wait: assert property (s_wait |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_ready_owned: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  a_start_one: assert property (conv_start |-> s_start_pulse)
    else $error("start too long");
  a_start_tick: assert property (conv_start |-> $past(adc_clk_en))
    else $error("start without tick");
  a_abort_cause: assert property (conv_abort |->
    $past(psel && penable && pready && pwrite) &&
    ($past(paddr) == A_CLK || $past(paddr) == A_SEQ))
    else $error("abort without write");
  a_irq_cause: assert property ($rose(adc_irq) |->
    $past(conv_done) || $past(psel && penable && pwrite))
    else $error("irq without cause");
  a_chan_hold: assert property ($changed(conv_chan) |->
    conv_start || $past(conv_start))
    else $error("channel moved");
endmodule : adc_seq_ctrl_monitor

bind adc_seq_ctrl adc_seq_ctrl_monitor adc_seq_ctrl_monitor_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .adc_irq(adc_irq), .adc_clk_en(adc_clk_en),
  .conv_start(conv_start), .conv_abort(conv_abort),
  .conv_chan(conv_chan), .conv_done(conv_done),
  .conv_result(conv_result));

// *** dv/adc_seq_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end

// ****************
// Bench top
// ****************
module adc_seq_ctrl_tb_top;
  logic        sys_clk, rst_n, psel, penable, pwrite, slow, last_err;
  logic        pready, pslverr, adc_irq, adc_clk_en, conv_done;
  logic        conv_start, conv_abort;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [3:0]  conv_chan;
  logic [9:0]  conv_result;
  int          errors, cmp_count, n;
  localparam logic [7:0] CLK = `ADC_IDX_CLK, SEQ = `ADC_IDX_SEQ,
    STA = `ADC_IDX_STAT, FLG = `ADC_IDX_FLAGS, IST = `ADC_IDX_IRQ_STAT,
    IEN = `ADC_IDX_IRQ_EN, ICL = `ADC_IDX_IRQ_CLR, RS0 = `ADC_IDX_RES0;

  adc_seq_ctrl adc_seq_ctrl_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_irq(adc_irq), .adc_clk_en(adc_clk_en),
    .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_chan(conv_chan), .conv_done(conv_done),
    .conv_result(conv_result));
  adc_seq_core_model adc_seq_core_model_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
    .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_chan(conv_chan), .conv_done(conv_done),
    .conv_result(conv_result));

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic test_done();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // One APB transfer; result left in v and last_err
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      test_done();
    end
    v        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] i, input logic [31:0] m, e);
    apb(1'b0, i, 32'h0);
    `CHK(v & m, e)
  endtask : rd_chk

  // Bounded poll until a masked bit shows up
  task automatic poll(input logic [7:0] i, input logic [31:0] m);
    n = 0;
    do begin
      apb(1'b0, i, 32'h0);
      n++;
    end while ((v & m) === 32'h0 && n < 200);
    if (n >= 200) begin
      errors++;
      test_done();
    end
  endtask : poll

  function automatic logic [9:0] res_of(input logic [3:0] c);
    return {c, 2'b01, c};
  endfunction : res_of

  // Run one sequence and check flags and each result slot the sequence fills
  task automatic check_seq(input logic [7:0] c);
    logic [3:0] ch;
    int         m;
    m = c[6] ? 8 : 4;
    // Start first, then clear: a scan left running cannot pre-set the flag
    wr(SEQ, {24'h0, c});
    wr(ICL, 32'h3);
    poll(IST, 32'h1);
    rd_chk(STA, 32'h3, 32'h1);
    rd_chk(FLG, 32'hff, c[6] ? 32'hff : 32'h0f);
    for (int k = 0; k < m; k++) begin
      ch = c[4] ? (c[3:0] & (c[6] ? 4'h8 : 4'hc)) + 4'(k) : c[3:0];
      rd_chk(RS0 + 8'(k), 32'h3ff, {22'h0, res_of(ch)});
    end
  endtask : check_seq

  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, slow} = '0;
    rst_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(SEQ, 32'hffffffff, 32'h0);
    rd_chk(CLK, 32'hffffffff, 32'h1);
    rd_chk(8'h00, 32'hffffffff, 32'h0);
    `CHK(last_err, 1'b1)
    wr(SEQ, 32'hff);
    rd_chk(SEQ, 32'hffffffff, 32'h7f);
    wr(IEN, 32'h0);
    check_seq(8'h05);
    @(negedge sys_clk);
    `CHK(adc_irq, 1'b0)
    wr(IEN, 32'h3);
    @(negedge sys_clk);
    `CHK(adc_irq, 1'b1)
    wr(ICL, 32'h3);
    @(negedge sys_clk);
    `CHK(adc_irq, 1'b0)
    check_seq(8'h14);
    slow <= 1'b1;
    check_seq(8'h50);
    check_seq(8'h1c);
    check_seq(8'h0b);
    // Scan repeats without a write, then a write aborts it
    wr(SEQ, 32'h22);
    poll(IST, 32'h1);
    wr(ICL, 32'h1);
    poll(IST, 32'h1);
    rd_chk(STA, 32'h2, 32'h2);
    wr(ICL, 32'h3);
    wr(SEQ, 32'h03);
    wr(ICL, 32'h1);
    rd_chk(FLG, 32'hff, 32'h0);
    rd_chk(STA, 32'h1, 32'h0);
    rd_chk(IST, 32'h2, 32'h2);
    poll(IST, 32'h1);
    rd_chk(FLG, 32'hff, 32'h0f);
    // Clock control write halts until the next sequence write
    wr(SEQ, 32'h07);
    wr(CLK, 32'h01);
    rd_chk(STA, 32'h4, 32'h4);
    n = 0;
    repeat (40) begin
      @(posedge sys_clk);
      if (conv_start === 1'b1) n++;
    end
    `CHK(n, 0)
    check_seq(8'h07);
    test_done();
  end
endmodule : adc_seq_ctrl_tb_top
